// ===== core/drc_pkg.sv
package drc_pkg;

  // ****************************************
  // Register indexes and byte addresses
  // ****************************************
  localparam logic [11:0] DRC_IDX_CH0_CRL = 12'h160;
  localparam logic [11:0] DRC_IDX_CH0_CRH = 12'h161;
  localparam logic [11:0] DRC_IDX_CH1_CRL = 12'h162;
  localparam logic [11:0] DRC_IDX_CH1_CRH = 12'h163;
  localparam logic [11:0] DRC_IDX_CH0_REF = 12'h164;
  localparam logic [11:0] DRC_IDX_CH1_REF = 12'h165;
  localparam int          DRC_ADDR_SHIFT  = 2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DRC_CRL_SFRC   = 7;
  localparam int DRC_CRL_BRM    = 5;
  localparam int DRC_CRL_MUXE   = 3;
  localparam int DRC_CRL_MUXW   = 1;
  localparam int DRC_CRL_MAC    = 0;
  localparam int DRC_CRH_WW     = 6;
  localparam int DRC_CRH_WR     = 4;
  localparam int DRC_CRH_PGE    = 3;
  localparam int DRC_REF_DM     = 7;
  localparam int DRC_REF_RS     = 4;
  localparam int DRC_REF_RW     = 1;
  localparam int DRC_REF_RC     = 0;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [7:0] DRC_CRL_RST  = 8'h80;
  localparam logic [7:0] DRC_CRH_RST  = 8'ha0;
  localparam logic [7:0] DRC_REF_RST  = 8'h00;
  localparam logic [7:0] DRC_CRL_MASK = 8'haf;
  localparam logic [7:0] DRC_CRH_MASK = 8'hf8;
  localparam logic [7:0] DRC_REF_MASK = 8'hff;

  // ****************************************
  // Timing in system clock cycles; mux width base in bits
  // ****************************************
  localparam logic [3:0] DRC_DUMMY_WIDTH  = 4'h4;
  localparam logic [2:0] DRC_DUMMY_PERIOD = 3'h6;
  localparam logic [3:0] DRC_WIDTH_BASE   = 4'h2;
  localparam logic [3:0] DRC_MUX_BASE     = 4'h8;
  localparam logic [1:0] DRC_PAGE_BASE    = 2'h1;

  // ****************************************
  // Channel states
  // ****************************************
  typedef enum logic [7:0] {
    DRC_ST_IDLE = 8'b00000001,
    DRC_ST_ACC  = 8'b00000010,
    DRC_ST_REF  = 8'b00000100,
    DRC_ST_SELF = 8'b00001000,
    DRC_ST_PARK = 8'b00010000,
    DRC_ST_REL  = 8'b00100000,
    DRC_ST_HOLD = 8'b01000000,
    DRC_ST_HREF = 8'b10000000
  } drc_state_t;

  // ****************************************
  // Per-channel configuration to the access path
  // ****************************************
  typedef struct packed {
    logic       addr_mux_on;
    logic [3:0] mux_bits;
    logic       page_access_on;
    logic [1:0] page_write_states;
    logic [1:0] page_read_states;
  } drc_cfg_t;

  // ****************************************
  // Strobe pins of one channel
  // ****************************************
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic oe;
  } drc_strobe_t;

  // Interval table in cycles
  function automatic logic [8:0] drc_interval(input logic [2:0] sel);
    unique case (sel)
      3'h0: drc_interval = 9'd78;
      3'h1: drc_interval = 9'd154;
      3'h2: drc_interval = 9'd188;
      3'h3: drc_interval = 9'd226;
      3'h4: drc_interval = 9'd246;
      3'h5: drc_interval = 9'd302;
      3'h6: drc_interval = 9'd308;
      3'h7: drc_interval = 9'd384;
    endcase
  endfunction

  // Index to byte address
  function automatic logic [31:0] drc_byte_addr(input logic [11:0] idx);
    drc_byte_addr = {18'h0, idx, 2'h0};
  endfunction

endpackage

// ===== core/drc_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Writing one to dummy_refresh_on starts back-to-back CBR dummy refreshes.
// - Dummy refresh stops on bit cleared, access control on, or interval on.
// - Those automatic stops leave the dummy_refresh_on bit unchanged.
// - Overlapping refresh and access: whichever began first finishes first.
// - Refresh and access requested together: refresh runs first.
// - Access waiting on a refresh gets wait states until refresh ends.
// - Release mode: finish cycle, drive strobes high, then float them.
// - Release mode: a waiting refresh runs before the bus is released.
// - During release at most one pending refresh per channel is kept.
// - On bus return the pending refresh runs at once.
// - Pin-hold mode keeps strobes driven and uses them only for refresh.
// - Pin-hold mode grants release with timing independent of refresh.
// - Channel 0 serves block area 1, channel 1 serves block area 3.
// - mux_length_sel codes 0..3 give 8, 9, 10, 11 bit multiplexing.
// - access_ctl_on enables DRAM access control; resets to zero.
// - Page wait codes 01 give 2 states, 10 give 3; others reserved.
// - page_access_on selects page mode accesses; resets to zero.
// - refresh_interval_sel spaces refreshes 78 to 384 cycles; resets 000.
// - refresh_width_sel gives refresh widths 2 through 9 cycles.
// - interval_refresh_on enables periodic refresh; resets to zero.
// - Dummy refresh cycles are 4 states wide, spaced 6 states apart.
// - self_refresh_ctl zero with interval_refresh_on set holds strobes low; halt release with run_mode_in low sets it back.
module drc_top
  import drc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        area1_acc_req,
  input  wire logic        area3_acc_req,
  input  wire logic        bus_request_in,
  input  wire logic        halt_release_in,
  input  wire logic        run_mode_in,
  output logic             bus_ack,
  output logic [1:0]       acc_grant,
  output logic [1:0]       acc_wait,
  output drc_strobe_t      strobe [2],
  output drc_cfg_t         cfg [2]
);

  // ****************************************
  // Register bus slave
  // ****************************************
  logic [7:0]  crl [2];
  logic [7:0]  crh [2];
  logic [7:0]  rfc [2];
  logic        wr_pend;
  logic [2:0]  wr_sel;
  logic [2:0]  addr_sel;
  logic [7:0]  rd_byte;
  logic        addr_phase;

  function automatic logic [2:0] reg_sel(input logic [31:0] a);
    if (a == drc_byte_addr(DRC_IDX_CH0_CRL)) reg_sel = 3'h0;
    else if (a == drc_byte_addr(DRC_IDX_CH0_CRH)) reg_sel = 3'h1;
    else if (a == drc_byte_addr(DRC_IDX_CH1_CRL)) reg_sel = 3'h2;
    else if (a == drc_byte_addr(DRC_IDX_CH1_CRH)) reg_sel = 3'h3;
    else if (a == drc_byte_addr(DRC_IDX_CH0_REF)) reg_sel = 3'h4;
    else if (a == drc_byte_addr(DRC_IDX_CH1_REF)) reg_sel = 3'h5;
    else reg_sel = 3'h7;
  endfunction

  assign addr_phase = hsel && hready && htrans[1];
  assign addr_sel   = reg_sel(haddr);

  always_comb begin
    unique case (addr_sel)
      3'h0: rd_byte = crl[0] & DRC_CRL_MASK;
      3'h1: rd_byte = crh[0] & DRC_CRH_MASK;
      3'h2: rd_byte = crl[1] & DRC_CRL_MASK;
      3'h3: rd_byte = crh[1] & DRC_CRH_MASK;
      3'h4: rd_byte = rfc[0];
      3'h5: rd_byte = rfc[1];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend   <= 1'b0;
      wr_sel    <= 3'h7;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= addr_phase && hwrite;
      wr_sel  <= addr_sel;
      if (addr_phase && !hwrite) begin
        hrdata <= {24'h0, rd_byte};
      end
    end
  end

  // ****************************************
  // Per-channel logic
  // ****************************************
  logic       acc_req [2];
  logic       released [2];
  assign acc_req[0] = area1_acc_req;
  assign acc_req[1] = area3_acc_req;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_request_in && released[0] && released[1];
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch
    // ****************************************
    // Channel state and timers
    // ****************************************
    drc_state_t state;
    drc_state_t next_state;
    logic [8:0] ivl_cnt;
    logic [2:0] dum_cnt;
    logic [3:0] ref_cnt;
    logic [3:0] ref_len;
    logic       pend;
    logic       ivl_tick;
    logic       dum_tick;
    logic       dum_active;
    logic       hw_wake;
    logic       wr_crl;
    logic       wr_crh;
    logic       wr_ref;
    logic       in_ref;

    // ****************************************
    // Write strobes and mode decode
    // ****************************************
    assign wr_crl = wr_pend && (wr_sel == 3'(2 * c));
    assign wr_crh = wr_pend && (wr_sel == 3'(2 * c + 1));
    assign wr_ref = wr_pend && (wr_sel == 3'(4 + c));
    assign hw_wake = halt_release_in && !run_mode_in;
    assign dum_active = rfc[c][DRC_REF_DM] && !crl[c][DRC_CRL_MAC]
                        && !rfc[c][DRC_REF_RC];
    assign ivl_tick = rfc[c][DRC_REF_RC] && state != DRC_ST_SELF
                      && ivl_cnt == drc_interval(rfc[c][6:4]) - 9'd1;
    assign dum_tick = dum_active && dum_cnt == 3'h0;
    assign ref_len = dum_active ? DRC_DUMMY_WIDTH
                     : DRC_WIDTH_BASE + {1'b0, rfc[c][3:1]};

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        crl[c] <= DRC_CRL_RST;
        crh[c] <= DRC_CRH_RST;
        rfc[c] <= DRC_REF_RST;
      end else begin
        if (wr_crl) begin
          crl[c] <= hwdata[7:0] & DRC_CRL_MASK;
        end
        if (hw_wake && state == DRC_ST_SELF) begin
          crl[c][DRC_CRL_SFRC] <= 1'b1;
        end
        if (wr_crh) begin
          crh[c] <= hwdata[7:0] & DRC_CRH_MASK;
        end
        if (wr_ref) begin
          rfc[c] <= hwdata[7:0];
        end
      end
    end

    // ****************************************
    // Interval and dummy timers
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ivl_cnt <= 9'h0;
        dum_cnt <= 3'h0;
      end else begin
        if (!rfc[c][DRC_REF_RC] || ivl_tick) begin
          ivl_cnt <= 9'h0;
        end else if (state != DRC_ST_SELF) begin
          ivl_cnt <= ivl_cnt + 9'd1;
        end
        if (!dum_active || dum_cnt == DRC_DUMMY_PERIOD - 3'h1) begin
          dum_cnt <= 3'h0;
        end else begin
          dum_cnt <= dum_cnt + 3'h1;
        end
      end
    end

    // ****************************************
    // Single pending refresh flag
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        pend <= 1'b0;
      end else if (ivl_tick || dum_tick) begin
        pend <= 1'b1;
      end else if (next_state == DRC_ST_REF && state != DRC_ST_REF) begin
        pend <= 1'b0;
      end else if (next_state == DRC_ST_HREF && state != DRC_ST_HREF) begin
        pend <= 1'b0;
      end
    end

    // ****************************************
    // Cycle sequencer
    // ****************************************
    always_comb begin
      next_state = state;
      unique case (state)
        DRC_ST_IDLE: begin
          if (!crl[c][DRC_CRL_SFRC] && rfc[c][DRC_REF_RC]) begin
            next_state = DRC_ST_SELF;
          end else if (bus_request_in && crl[c][DRC_CRL_BRM]) begin
            next_state = DRC_ST_HOLD;
          end else if (pend) begin
            next_state = DRC_ST_REF;
          end else if (bus_request_in) begin
            next_state = DRC_ST_PARK;
          end else if (acc_req[c] && crl[c][DRC_CRL_MAC]) begin
            next_state = DRC_ST_ACC;
          end
        end
        DRC_ST_ACC: begin
          if (!acc_req[c]) begin
            next_state = DRC_ST_IDLE;
          end
        end
        DRC_ST_REF: begin
          if (ref_cnt == 4'h0) begin
            next_state = DRC_ST_IDLE;
          end
        end
        DRC_ST_SELF: begin
          if (crl[c][DRC_CRL_SFRC]) begin
            next_state = DRC_ST_IDLE;
          end
        end
        DRC_ST_PARK: next_state = DRC_ST_REL;
        DRC_ST_REL: begin
          if (!bus_request_in) begin
            next_state = pend ? DRC_ST_REF : DRC_ST_IDLE;
          end
        end
        DRC_ST_HOLD: begin
          if (!bus_request_in) begin
            next_state = DRC_ST_IDLE;
          end else if (pend) begin
            next_state = DRC_ST_HREF;
          end
        end
        DRC_ST_HREF: begin
          if (ref_cnt == 4'h0) begin
            next_state = DRC_ST_HOLD;
          end
        end
        default: next_state = DRC_ST_IDLE;
      endcase
    end

    assign in_ref = next_state == DRC_ST_REF || next_state == DRC_ST_HREF;

    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        state   <= DRC_ST_IDLE;
        ref_cnt <= 4'h0;
      end else begin
        state <= next_state;
        if (in_ref && state != next_state) begin
          ref_cnt <= ref_len - 4'h1;
        end else if (ref_cnt != 4'h0) begin
          ref_cnt <= ref_cnt - 4'h1;
        end
      end
    end

    assign released[c] = state == DRC_ST_REL || state == DRC_ST_HOLD
                         || state == DRC_ST_HREF;

    // ****************************************
    // Strobes, CAS before RAS on refresh
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        strobe[c] <= '{ras_n: 1'b1, cas_n: 1'b1, oe: 1'b1};
      end else begin
        strobe[c].cas_n <= !(in_ref || next_state == DRC_ST_SELF
                             || next_state == DRC_ST_ACC);
        strobe[c].ras_n <= !((in_ref && state == next_state)
                             || next_state == DRC_ST_SELF
                             || next_state == DRC_ST_ACC);
        strobe[c].oe    <= next_state != DRC_ST_REL;
      end
    end

    // ****************************************
    // Access handshake
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        acc_grant[c] <= 1'b0;
        acc_wait[c]  <= 1'b0;
      end else begin
        acc_grant[c] <= next_state == DRC_ST_ACC;
        acc_wait[c]  <= acc_req[c] && crl[c][DRC_CRL_MAC]
                        && next_state != DRC_ST_ACC;
      end
    end

    // ****************************************
    // Access path configuration
    // ****************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        cfg[c] <= '0;
      end else begin
        cfg[c].addr_mux_on <= crl[c][DRC_CRL_MUXE];
        cfg[c].mux_bits    <= DRC_MUX_BASE
                              + {2'h0, crl[c][2:1]};
        cfg[c].page_access_on    <= crh[c][DRC_CRH_PGE];
        cfg[c].page_write_states <= crh[c][7:6] + DRC_PAGE_BASE;
        cfg[c].page_read_states  <= crh[c][5:4] + DRC_PAGE_BASE;
      end
    end
  end

endmodule // drc_top

// ===== tb/drc_checker_properties.sv
`timescale 1ns/1ns
// ****
// Port checks
// ****
module drc_checker
  import drc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       resetn,
  input wire logic       area1_acc_req,
  input wire logic       area3_acc_req,
  input wire logic       bus_request_in,
  input wire logic       bus_ack,
  input wire logic [1:0] acc_grant,
  input wire logic [1:0] acc_wait,
  input drc_strobe_t     strobe [2],
  input drc_cfg_t        cfg [2]
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  grant_low_a: assert property (
    acc_grant[0] |-> !strobe[0].ras_n && !strobe[0].cas_n)
    else $error("grant with strobes high");
  area1_grant_a: assert property (
    $rose(acc_grant[0]) |-> $past(area1_acc_req))
    else $error("grant 0 without request");
  area3_grant_a: assert property (
    $rose(acc_grant[1]) |-> $past(area3_acc_req))
    else $error("grant 1 without request");
  refresh_first_a: assert property (
    area1_acc_req && !acc_grant[0] && !strobe[0].cas_n |=> !acc_grant[0])
    else $error("access cut into refresh");
  wait_excl_a: assert property (acc_wait[1] |-> !acc_grant[1])
    else $error("wait and grant together");
  cas_first_a: assert property (
    $fell(strobe[1].cas_n) && strobe[1].ras_n |=> !strobe[1].ras_n)
    else $error("refresh row strobe late");
  park_high_a: assert property (
    $fell(strobe[0].oe) |-> $past(strobe[0].ras_n) && $past(strobe[0].cas_n))
    else $error("float without park");
  float_idle_a: assert property (!strobe[1].oe |-> !acc_grant[1])
    else $error("access while floated");
  ack_cause_a: assert property ($rose(bus_ack) |-> $past(bus_request_in))
    else $error("ack without request");
  ack_quiet_a: assert property (bus_ack |-> acc_grant == 2'h0)
    else $error("access during release");
  mux_range_a: assert property (
    $past(resetn) |-> cfg[1].mux_bits inside {[4'h8:4'hb]})
    else $error("mux width out of range");
endmodule // drc_checker

bind drc_top drc_checker drc_checker_inst (
  .sys_clk(sys_clk), .resetn(resetn), .area1_acc_req(area1_acc_req),
  .area3_acc_req(area3_acc_req), .bus_request_in(bus_request_in),
  .bus_ack(bus_ack), .acc_grant(acc_grant), .acc_wait(acc_wait),
  .strobe(strobe), .cfg(cfg)
);

// ===== tb/drc_mem_model.sv
`timescale 1ns/1ns
// ****
// DRAM chips and outside bus master
// ****
module drc_mem_model
  import drc_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic   resetn,
  input  drc_strobe_t strobe [2],
  input  wire logic   want_bus,
  output logic        bus_request_in,
  output int          cnt [2],
  output int          wid [2],
  output int          gap [2]
);
  int   age [2];
  int   run [2];
  logic cbr [2];
  logic ras;
  logic cas;
  always @(posedge sys_clk) begin
    bus_request_in <= want_bus;
  end
  always @(posedge sys_clk or negedge resetn) begin
    for (int c = 0; c < 2; c++) begin
      ras = strobe[c].oe ? strobe[c].ras_n : 1'b1;
      cas = strobe[c].oe ? strobe[c].cas_n : 1'b1;
      if (!resetn) begin
        cnt[c] <= 0;
        wid[c] <= 0;
        gap[c] <= 0;
        age[c] <= 0;
        run[c] <= 0;
        cbr[c] <= 1'b0;
      end else begin
        age[c] <= age[c] + 1;
        run[c] <= cas ? 0 : run[c] + 1;
        if (!cas && ras && run[c] == 0) begin
          cnt[c] <= cnt[c] + 1;
          gap[c] <= age[c];
          age[c] <= 1;
          cbr[c] <= 1'b1;
        end
        if (cas && run[c] != 0 && cbr[c]) begin
          wid[c] <= run[c];
          cbr[c] <= 1'b0;
        end
      end
    end
  end
endmodule // drc_mem_model

// ===== tb/tb_dram_refresh_and_access_control.sv
`timescale 1ns/1ns
module tb_dram_refresh_and_access_control
  import drc_pkg::*;
;
  logic        sys_clk = 1'b0, resetn, hsel, hwrite, hreadyout, hresp;
  logic        a1, a3, want, halt, run, bus_request_in, bus_ack;
  logic [1:0]  htrans, acc_grant, acc_wait;
  logic [31:0] haddr, hwdata, hrdata, seed, r;
  logic [7:0]  b;
  drc_strobe_t strobe [2];
  drc_cfg_t    cfg [2];
  int          cnt [2], wid [2], gap [2];
  int          err_total = 0, n_compared = 0, n, m, t;
  drc_top drc_top_inst (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .area1_acc_req(a1), .area3_acc_req(a3),
    .bus_request_in(bus_request_in), .halt_release_in(halt),
    .run_mode_in(run), .bus_ack(bus_ack), .acc_grant(acc_grant),
    .acc_wait(acc_wait), .strobe(strobe), .cfg(cfg)
  );
  drc_mem_model drc_mem_model_inst (
    .sys_clk(sys_clk), .resetn(resetn), .strobe(strobe), .want_bus(want),
    .bus_request_in(bus_request_in), .cnt(cnt), .wid(wid), .gap(gap)
  );
  // ****
  // Helpers
  // ****
  always #10 sys_clk = ~sys_clk;
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, i, 2'h0};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h0);
    chk("reg", {24'h0, e}, hrdata);
  endtask
  task automatic until_cnt(input int c, input int k);
    n = cnt[c] + k;
    for (t = 0; cnt[c] < n && t < 3000; t++)
      @(posedge sys_clk);
    chk("refreshes", n, cnt[c]);
  endtask
  task automatic until_grant(input int c);
    for (t = 0; acc_grant[c] !== 1'b1 && t < 400; t++)
      @(posedge sys_clk);
    chk("grant", 1, acc_grant[c]);
  endtask
  task automatic until_ack();
    for (t = 0; bus_ack !== 1'b1 && t < 500; t++)
      @(posedge sys_clk);
    chk("ack", 1, bus_ack);
  endtask
  function automatic int intv(input int i);
    int v [8] = '{78, 154, 188, 226, 246, 302, 308, 384};
    return v[i];
  endfunction
  initial begin
    wt(40000);
    err_total++;
    end_sim();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {resetn, hsel, hwrite, a1, a3, want, halt, run} = 8'h0;
    {htrans, haddr, hwdata} = 66'h0;
    seed = 32'hcb853561;
    wt(12);
    resetn <= 1'b1;
    wt(1);
    bus(1'b1, 12'h166, 8'hff);
    for (int i = 0; i < 7; i++)
      rd(12'h160 + 12'(i), i > 3 ? 8'h00 : (i[0] ? 8'ha0 : 8'h80));
    chk("resp", 0, hresp);
    repeat (12) begin
      r = $random(seed);
      b = {r[2], ~r[2], r[3], ~r[3], r[4], 3'h0};
      bus(1'b1, 12'h160 + {10'h0, r[8], 1'b0}, {5'h11, r[1:0], 1'b0});
      bus(1'b1, 12'h161, b);
      bus(1'b1, 12'h163, b);
      rd(12'h161 + {10'h0, r[8], 1'b0}, b);
      chk("cfg", {3'h6, r[1:0], r[4], 1'b1, r[2], 1'b1, r[3]}, cfg[r[8]]);
    end
    bus(1'b1, 12'h160, 8'h88);
    bus(1'b1, 12'h164, 8'h80);
    until_cnt(0, 3);
    chk("dummy gap", 6, gap[0]);
    chk("dummy width", 4, wid[0]);
    bus(1'b1, 12'h160, 8'h89);
    wt(4);
    m = cnt[0];
    wt(30);
    chk("dummy off", m, cnt[0]);
    rd(12'h164, 8'h80);
    bus(1'b1, 12'h160, 8'h88);
    bus(1'b1, 12'h164, 8'h81);
    rd(12'h164, 8'h81);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 12'h164, {1'b0, 3'(i), 3'(i), 1'b1});
      until_cnt(0, 3);
      chk("interval", intv(i), gap[0]);
      chk("width", 2 + i, wid[0]);
    end
    bus(1'b1, 12'h164, 8'h03);
    bus(1'b1, 12'h165, 8'h13);
    a1 <= 1'b1;
    wt(10);
    chk("no access", 0, {acc_grant[0], acc_wait[0]});
    bus(1'b1, 12'h160, 8'h89);
    until_grant(0);
    a1 <= 1'b0;
    m = cnt[0];
    for (t = 0; cnt[0] == m && t < 200; t++)
      @(posedge sys_clk);
    a1 <= 1'b1;
    wt(2);
    chk("wait", 1, acc_wait[0]);
    until_grant(0);
    chk("refresh done", 3, wid[0]);
    a1 <= 1'b0;
    bus(1'b1, 12'h162, 8'h89);
    repeat (400) begin
      r = $random(seed);
      a1 <= a1 ? !acc_grant[0] : r[0] & !acc_grant[0];
      a3 <= a3 ? !acc_grant[1] : r[1] & !acc_grant[1];
      @(posedge sys_clk);
    end
    {a1, a3} <= 2'h0;
    want <= 1'b1;
    until_ack();
    chk("floated", 0, {strobe[0].oe, strobe[1].oe});
    m = cnt[0];
    wt(200);
    chk("none released", m, cnt[0]);
    want <= 1'b0;
    until_cnt(0, 1);
    chk("at once", 1, t < 8);
    bus(1'b1, 12'h160, 8'ha9);
    bus(1'b1, 12'h162, 8'ha9);
    want <= 1'b1;
    until_ack();
    m = cnt[0];
    a1 <= 1'b1;
    wt(200);
    chk("held refresh", 1, cnt[0] > m + 1);
    chk("held pins", 2, {strobe[0].oe, acc_grant[0]});
    want <= 1'b0;
    until_grant(0);
    a1 <= 1'b0;
    bus(1'b1, 12'h160, 8'h29);
    wt(200);
    chk("self", 0, {strobe[0].ras_n, strobe[0].cas_n});
    run <= 1'b1;
    halt <= 1'b1;
    wt(2);
    rd(12'h160, 8'h29);
    run <= 1'b0;
    wt(1);
    halt <= 1'b0;
    wt(4);
    rd(12'h160, 8'ha9);
    end_sim();
  end
endmodule // tb_dram_refresh_and_access_control
